/* low_power_card_detect_threshold_compare.sv */
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module low_power_card_detect_threshold_compare (
  input  wire logic          CLOCK,
  input  wire logic          RESET_N,
  input  wire logic [9:0]    AWADDR,
  input  wire logic          AWVALID,
  output logic               AWREADY,
  input  wire logic [31:0]   WDATA,
  input  wire logic [3:0]    WSTRB,
  input  wire logic          WVALID,
  output logic               WREADY,
  output logic [1:0]         BRESP,
  output logic               BVALID,
  input  wire logic          BREADY,
  input  wire logic [9:0]    ARADDR,
  input  wire logic          ARVALID,
  output logic               ARREADY,
  output logic [31:0]        RDATA,
  output logic [1:0]         RRESP,
  output logic               RVALID,
  input  wire logic          RREADY,
  input  wire logic          RUN_START,
  input  wire logic          SAMPLE_VALID,
  input  wire low_power_card_detect_pkg::iq_t SAMPLE,
  input  wire logic          RUN_END,
  output logic               DETECT_HIGH_DRIVE,
  output logic               DETECT_IRQ
);
  typedef struct packed {
    logic [7:0]     qlo;
    logic [7:0]     qhi;
    logic [7:0]     ilo;
    low_power_card_detect_pkg::iq_t  res;
    logic           sup;
    logic           hd;
    logic           fe;
    logic           qu;
    logic           iu;
    logic           irq;
    low_power_card_detect_pkg::run_t run;
    logic [7:0]     cnt;
    logic           aw_ok;
    logic [7:0]     aw_idx;
    logic           w_ok;
    logic [7:0]     wd;
    logic           wstb;
    logic           bv;
    logic [1:0]     br;
    logic           rv;
    logic [31:0]    rd;
    logic [1:0]     rr;
  } s_t;
  s_t s_q;
  s_t s_d;

  low_power_card_detect_pkg::iq_t filt;
  low_power_card_detect_pkg::iq_t last;
  low_power_card_detect_pkg::iq_t meas;
  logic          f_iu;
  logic          f_qu;
  logic          take;
  logic          clear;
  logic          wr_fire;
  logic          end_fire;
  logic          hit;
  logic [5:0]    i_up;
  logic [8:0]    rword;

  // ===========================================================
  // helpers
  function automatic logic mapped(input logic [7:0] idx);
    case (idx)
      low_power_card_detect_pkg::OPT_IDX, low_power_card_detect_pkg::QLO_IDX, low_power_card_detect_pkg::QHI_IDX,
      low_power_card_detect_pkg::ILO_IDX, low_power_card_detect_pkg::RESI_IDX, low_power_card_detect_pkg::RESQ_IDX,
      low_power_card_detect_pkg::IRQ_IDX: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // bit 8 is the valid mark, bits 7:0 the register value
  function automatic logic [8:0] read_reg(input s_t s,
                                          input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      low_power_card_detect_pkg::OPT_IDX: begin
        // flags shown only while filtering, they mean nothing otherwise
        v = {4'h0, s.hd, s.fe, s.fe & s.qu, s.fe & s.iu};
      end
      low_power_card_detect_pkg::QLO_IDX:  v = s.qlo;
      low_power_card_detect_pkg::QHI_IDX:  v = s.qhi;
      low_power_card_detect_pkg::ILO_IDX:  v = s.ilo;
      low_power_card_detect_pkg::RESI_IDX: v = {2'b00, s.res.i};
      low_power_card_detect_pkg::RESQ_IDX: v = {1'b0, s.sup, s.res.q};
      low_power_card_detect_pkg::IRQ_IDX:  v[low_power_card_detect_pkg::IRQ_BIT] = s.irq;
      default:            v = 8'h00;
    endcase
    return {mapped(idx), v};
  endfunction

  // ===========================================================
  // filter
  assign take  = SAMPLE_VALID && s_q.run == low_power_card_detect_pkg::RUN_MEASURE
                 && s_q.cnt < 8'(low_power_card_detect_pkg::SAMPLE_MAX_CYC);
  assign clear = RUN_START;

  detect_filter u_filter (
    .clock   (CLOCK),
    .reset_n (RESET_N),
    .clear   (clear),
    .take    (take),
    .raw     (SAMPLE),
    .filt    (filt),
    .last    (last),
    .i_unst  (f_iu),
    .q_unst  (f_qu)
  );

  // ===========================================================
  // comparison
  assign i_up = {s_q.qlo[7:6], s_q.qhi[7:6], s_q.ilo[7:6]};
  assign meas = s_q.fe ? filt : last;
  assign hit  = (meas.i > i_up)
             || (meas.i < s_q.ilo[5:0])
             || (meas.q > s_q.qhi[5:0])
             || (meas.q < s_q.qlo[5:0]);
  assign end_fire = RUN_END && s_q.run == low_power_card_detect_pkg::RUN_MEASURE;
  assign rword    = read_reg(s_q, ARADDR[9:2]);

  // ===========================================================
  // next state
  always_comb begin
    s_d     = s_q;
    wr_fire = 1'b0;
    if (AWVALID && AWREADY) begin
      s_d.aw_ok  = 1'b1;
      s_d.aw_idx = AWADDR[9:2];
    end
    if (WVALID && WREADY) begin
      s_d.w_ok = 1'b1;
      s_d.wd   = WDATA[7:0];
      s_d.wstb = WSTRB[0];
    end
    if (BVALID && BREADY) begin
      s_d.bv = 1'b0;
    end
    if (s_d.aw_ok && s_d.w_ok) begin
      wr_fire   = 1'b1;
      s_d.aw_ok = 1'b0;
      s_d.w_ok  = 1'b0;
      s_d.bv    = 1'b1;
      s_d.br    = mapped(s_d.aw_idx) ? low_power_card_detect_pkg::RESP_OKAY
                                     : low_power_card_detect_pkg::RESP_SLVERR;
      if (s_d.wstb) begin
        case (s_d.aw_idx)
          low_power_card_detect_pkg::OPT_IDX: begin
            s_d.hd = s_d.wd[low_power_card_detect_pkg::HD_BIT];
            s_d.fe = s_d.wd[low_power_card_detect_pkg::FE_BIT];
          end
          low_power_card_detect_pkg::QLO_IDX: s_d.qlo = s_d.wd;
          low_power_card_detect_pkg::QHI_IDX: s_d.qhi = s_d.wd;
          low_power_card_detect_pkg::ILO_IDX: s_d.ilo = s_d.wd;
          low_power_card_detect_pkg::RESQ_IDX: s_d.sup = s_d.wd[low_power_card_detect_pkg::SUP_BIT];
          low_power_card_detect_pkg::IRQ_IDX: begin
            if (s_d.wd[low_power_card_detect_pkg::IRQ_BIT]) begin
              s_d.irq = 1'b0;
            end
          end
          default: s_d.sup = s_d.sup;
        endcase
      end
    end
    if (RVALID && RREADY) begin
      s_d.rv = 1'b0;
    end
    if (ARVALID && ARREADY) begin
      s_d.rv = 1'b1;
      s_d.rd = {24'h000000, rword[7:0]};
      s_d.rr = rword[8] ? low_power_card_detect_pkg::RESP_OKAY : low_power_card_detect_pkg::RESP_SLVERR;
    end
    // run sequencing comes after the bus so a hardware set beats a clear
    case (s_q.run)
      low_power_card_detect_pkg::RUN_IDLE: begin
        if (RUN_START) begin
          s_d.run = low_power_card_detect_pkg::RUN_MEASURE;
          s_d.cnt = 8'h00;
          s_d.sup = 1'b0;
        end
      end
      low_power_card_detect_pkg::RUN_MEASURE: begin
        if (s_q.cnt != 8'hff) begin
          s_d.cnt = s_q.cnt + 8'h01;
        end
        if (RUN_START) begin
          s_d.cnt = 8'h00;
          s_d.sup = 1'b0;
        end else if (RUN_END) begin
          s_d.run = low_power_card_detect_pkg::RUN_IDLE;
          s_d.res = meas;
          s_d.iu  = f_iu;
          s_d.qu  = f_qu;
          if (hit && !s_d.sup) begin
            s_d.irq = 1'b1;
          end
        end
      end
      default: s_d.run = low_power_card_detect_pkg::RUN_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      s_q     <= '0;
      s_q.qlo <= low_power_card_detect_pkg::REG_RST;
      s_q.qhi <= low_power_card_detect_pkg::REG_RST;
      s_q.ilo <= low_power_card_detect_pkg::REG_RST;
      s_q.run <= low_power_card_detect_pkg::RUN_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ===========================================================
  // outputs
  assign AWREADY           = !s_q.aw_ok && !s_q.bv;
  assign WREADY            = !s_q.w_ok && !s_q.bv;
  assign BVALID            = s_q.bv;
  assign BRESP             = s_q.br;
  assign ARREADY           = !s_q.rv;
  assign RVALID            = s_q.rv;
  assign RDATA             = s_q.rd;
  assign RRESP             = s_q.rr;
  assign DETECT_HIGH_DRIVE = s_q.hd;
  assign DETECT_IRQ        = s_q.irq;

  // ===========================================================
  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  sequence opt_write;
    wr_fire && s_d.wstb && s_d.aw_idx == low_power_card_detect_pkg::OPT_IDX;
  endsequence
  sequence run_hit(logic c);
    end_fire && !RUN_START && !s_d.sup && c;
  endsequence
  sequence reg_write(logic [7:0] idx, logic c);
    wr_fire && s_d.wstb && s_d.aw_idx == idx && c;
  endsequence

  drive_select_a: assert property (
    opt_write |=> DETECT_HIGH_DRIVE == $past(s_d.wd[low_power_card_detect_pkg::HD_BIT]))
    else $error("high drive not taken from options");
  upper_i_a: assert property (
    run_hit(meas.i > i_up) |=> DETECT_IRQ ##1 (DETECT_IRQ || $past(wr_fire)))
    else $error("upper i border miss");
  lower_i_a: assert property (
    run_hit(meas.i < s_q.ilo[5:0]) |=> DETECT_IRQ)
    else $error("lower i border miss");
  upper_q_a: assert property (
    run_hit(meas.q > s_q.qhi[5:0]) |=> DETECT_IRQ)
    else $error("upper q border miss");
  suppress_hold_a: assert property (
    end_fire && s_q.sup && !wr_fire && !DETECT_IRQ |=> !DETECT_IRQ)
    else $error("irq raised while suppressed");
  start_lift_a: assert property (
    RUN_START && !wr_fire |=> !s_q.sup)
    else $error("suppress not lifted at run start");
  result_hold_a: assert property (
    !end_fire |=> $stable(s_q.res))
    else $error("result moved outside run end");
  result_read_a: assert property (
    ARVALID && ARREADY && ARADDR[9:2] == low_power_card_detect_pkg::RESI_IDX && !end_fire
    |=> RVALID && RDATA == {26'h0, s_q.res.i})
    else $error("i result read wrong");
  opt_read_a: assert property (
    ARVALID && ARREADY && ARADDR[9:2] == low_power_card_detect_pkg::OPT_IDX && !s_q.fe
    |=> RVALID && RDATA[7:4] == 4'h0 && RDATA[1:0] == 2'b00)
    else $error("options read shows stale flags");
  sample_window_a: assert property (
    SAMPLE_VALID && !RUN_START && s_q.cnt >= 8'(low_power_card_detect_pkg::SAMPLE_MAX_CYC)
    |=> $stable(filt) && $stable(last))
    else $error("sample taken after window");
  irq_clear_a: assert property (
    reg_write(low_power_card_detect_pkg::IRQ_IDX, s_d.wd[low_power_card_detect_pkg::IRQ_BIT] && !end_fire)
    |=> !DETECT_IRQ)
    else $error("detection flag not cleared by write");
  ilo_write_a: assert property (
    reg_write(low_power_card_detect_pkg::ILO_IDX, 1'b1) |=> s_q.ilo == $past(s_d.wd))
    else $error("i lower border write lost");
  suppress_write_a: assert property (
    reg_write(low_power_card_detect_pkg::RESQ_IDX, !RUN_START)
    |=> s_q.sup == $past(s_d.wd[low_power_card_detect_pkg::SUP_BIT]))
    else $error("suppress bit write lost");
  result_update_a: assert property (
    end_fire && !RUN_START |=> s_q.res == $past(meas))
    else $error("result not taken at run end");
  filter_select_a: assert property (
    end_fire && !RUN_START && s_q.fe |=> s_q.res == $past(filt))
    else $error("filtered result not used");
  unstable_flag_a: assert property (
    end_fire && !RUN_START
    |=> s_q.iu == $past(f_iu) && s_q.qu == $past(f_qu))
    else $error("instability flags not taken");
  result_q_read_a: assert property (
    ARVALID && ARREADY && ARADDR[9:2] == low_power_card_detect_pkg::RESQ_IDX && !end_fire
    |=> RVALID && RDATA[7] == 1'b0 && RDATA[5:0] == s_q.res.q)
    else $error("q result read wrong");
  start_measure_a: assert property (
    RUN_START |=> s_q.run == low_power_card_detect_pkg::RUN_MEASURE && s_q.cnt == 8'h00)
    else $error("run start did not open the window");
endmodule

/* low_power_card_detect_pkg.sv */
package low_power_card_detect_pkg;
  // ===========================================================
  // register indices, byte address is four times the index
  localparam logic [7:0] OPT_IDX  = 8'h3a;
  localparam logic [7:0] QLO_IDX  = 8'h3f;
  localparam logic [7:0] QHI_IDX  = 8'h40;
  localparam logic [7:0] ILO_IDX  = 8'h41;
  localparam logic [7:0] RESI_IDX = 8'h42;
  localparam logic [7:0] RESQ_IDX = 8'h43;
  localparam logic [7:0] IRQ_IDX  = 8'h07;
  // ===========================================================
  // field positions
  localparam int HD_BIT  = 3;
  localparam int FE_BIT  = 2;
  localparam int QU_BIT  = 1;
  localparam int IU_BIT  = 0;
  localparam int SUP_BIT = 6;
  localparam int IRQ_BIT = 2;
  // ===========================================================
  // timing and reset values
  localparam int CLK_MHZ        = 25;
  localparam int SAMPLE_MAX_NS  = 4720;
  localparam int SAMPLE_MAX_CYC = SAMPLE_MAX_NS * CLK_MHZ / 1000;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ===========================================================
  // types
  typedef enum logic [1:0] {
    RUN_IDLE    = 2'b01,
    RUN_MEASURE = 2'b10
  } run_t;
  typedef struct packed {
    logic [5:0] i;
    logic [5:0] q;
  } iq_t;
endpackage

/* detect_filter.sv */
`timescale 1ns/1ns
module detect_filter (
  input  wire logic          clock,
  input  wire logic          reset_n,
  input  wire logic          clear,
  input  wire logic          take,
  input  wire low_power_card_detect_pkg::iq_t raw,
  output low_power_card_detect_pkg::iq_t      filt,
  output low_power_card_detect_pkg::iq_t      last,
  output logic               i_unst,
  output logic               q_unst
);
  typedef struct packed {
    low_power_card_detect_pkg::iq_t filt;
    low_power_card_detect_pkg::iq_t last;
    logic          have;
    logic          iu;
    logic          qu;
  } f_t;
  f_t s_q;
  f_t s_d;

  // running mean of previous filter output and new sample, halves single-sample noise at no memory cost
  function automatic logic [5:0] avg(input logic [5:0] a,
                                     input logic [5:0] b);
    logic [6:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    return sum[6:1];
  endfunction

  // ===========================================================
  // filter and change detection
  always_comb begin
    s_d = s_q;
    if (clear) begin
      s_d = '0;
    end else if (take) begin
      s_d.have   = 1'b1;
      s_d.last   = raw;
      s_d.filt.i = s_q.have ? avg(s_q.filt.i, raw.i) : raw.i;
      s_d.filt.q = s_q.have ? avg(s_q.filt.q, raw.q) : raw.q;
      s_d.iu = s_q.iu | (s_q.have & (raw.i != s_q.last.i));
      s_d.qu = s_q.qu | (s_q.have & (raw.q != s_q.last.q));
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign filt   = s_q.filt;
  assign last   = s_q.last;
  assign i_unst = s_q.iu;
  assign q_unst = s_q.qu;

  // ===========================================================
  // checks
  change_flag_a: assert property (@(posedge clock) disable iff (!reset_n)
    take && !clear && s_q.have && raw.i != s_q.last.i |=> i_unst)
    else $error("i change not flagged");
endmodule

/* tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  // ===========================================================
  // design signals
  logic          CLOCK = 1'b0;
  logic          RESET_N, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic          RUN_START, SAMPLE_VALID, RUN_END;
  logic [9:0]    AWADDR, ARADDR;
  logic [31:0]   WDATA, RDATA;
  logic [3:0]    WSTRB;
  logic [1:0]    BRESP, RRESP;
  logic          AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic          DETECT_HIGH_DRIVE, DETECT_IRQ;
  low_power_card_detect_pkg::iq_t SAMPLE;
  int            mismatches, total_checks, seed, k;
  logic [7:0]    qlo, qhi, ilo;
  logic          irq_e, sup_e;
  logic [1:0]    resp;
  logic [3:0]    wstb;
  logic [31:0]   rdat;
  logic [7:0]    idxs [7];

  low_power_card_detect_threshold_compare i_dut (.CLOCK(CLOCK), .RESET_N(RESET_N),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .RUN_START(RUN_START), .SAMPLE_VALID(SAMPLE_VALID),
    .SAMPLE(SAMPLE), .RUN_END(RUN_END),
    .DETECT_HIGH_DRIVE(DETECT_HIGH_DRIVE), .DETECT_IRQ(DETECT_IRQ));

  always #20 CLOCK = ~CLOCK;

  // ===========================================================
  // checking and closing
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk8(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask

  task chk1(input logic g, input logic e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask

  // ===========================================================
  // register bus, ready lines held high throughout
  task axi_wr(input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    AWADDR <= {idx, 2'b00};
    WDATA <= {24'h0, d};
    WSTRB <= wstb;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    do begin
      @(posedge CLOCK);
      n++;
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
    end while (!BVALID && n < 50);
    resp = BRESP;
    if (n >= 50) mismatches++;
  endtask

  task axi_rd(input logic [7:0] idx);
    int n;
    n = 0;
    ARADDR <= {idx, 2'b00};
    ARVALID <= 1'b1;
    do begin
      @(posedge CLOCK);
      n++;
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
    end while (!RVALID && n < 50);
    rdat = RDATA;
    resp = RRESP;
    if (n >= 50) mismatches++;
  endtask

  task rchk(input logic [7:0] idx, input logic [7:0] e);
    axi_rd(idx);
    chk8(rdat[7:0], e);
  endtask

  // ===========================================================
  // detection runs
  function automatic logic hit(input logic [5:0] i, input logic [5:0] q);
    hit = i > {qlo[7:6], qhi[7:6], ilo[7:6]} || i < ilo[5:0] ||
          q > qhi[5:0] || q < qlo[5:0];
  endfunction

  task bord(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    qlo = a;
    qhi = b;
    ilo = c;
    axi_wr(low_power_card_detect_pkg::QLO_IDX, a);
    axi_wr(low_power_card_detect_pkg::QHI_IDX, b);
    axi_wr(low_power_card_detect_pkg::ILO_IDX, c);
  endtask

  task run(input logic [5:0] i1, q1, i2, q2, input logic f, s);
    logic [5:0] ei, eq;
    RUN_START <= 1'b1;
    sup_e = 1'b0;
    @(posedge CLOCK);
    RUN_START <= 1'b0;
    if (s) begin
      axi_wr(low_power_card_detect_pkg::RESQ_IDX, 8'h40);
      sup_e = 1'b1;
    end
    SAMPLE_VALID <= 1'b1;
    SAMPLE <= {i1, q1};
    @(posedge CLOCK);
    SAMPLE <= {i2, q2};
    @(posedge CLOCK);
    SAMPLE_VALID <= 1'b0;
    RUN_END <= 1'b1;
    @(posedge CLOCK);
    RUN_END <= 1'b0;
    SAMPLE_VALID <= 1'b1;
    SAMPLE <= {~i2, ~q2};
    @(posedge CLOCK);
    SAMPLE_VALID <= 1'b0;
    // filtered value only exact for even sums, stimulus keeps to those
    ei = f ? 6'((int'(i1) + int'(i2)) / 2) : i2;
    eq = f ? 6'((int'(q1) + int'(q2)) / 2) : q2;
    if (hit(ei, eq) && !sup_e) irq_e = 1'b1;
    chk1(DETECT_IRQ, irq_e);
    rchk(low_power_card_detect_pkg::RESI_IDX, {2'b00, ei});
    rchk(low_power_card_detect_pkg::RESQ_IDX, {1'b0, sup_e, eq});
    axi_rd(low_power_card_detect_pkg::IRQ_IDX);
    chk1(rdat[low_power_card_detect_pkg::IRQ_BIT], irq_e);
    axi_wr(low_power_card_detect_pkg::IRQ_IDX, 8'(1 << low_power_card_detect_pkg::IRQ_BIT));
    irq_e = 1'b0;
    chk1(DETECT_IRQ, irq_e);
  endtask

  // ===========================================================
  // main sequence
  initial begin
    {RESET_N, AWVALID, WVALID, ARVALID, RUN_START, SAMPLE_VALID} = '0;
    {RUN_END, AWADDR, ARADDR, WDATA, WSTRB, SAMPLE} = '0;
    {BREADY, RREADY} = 2'b11;
    wstb = 4'hf;
    {mismatches, total_checks, irq_e, sup_e} = '0;
    seed = 32'ha9f0ed5f;
    idxs = '{8'h3a, 8'h3f, 8'h40, 8'h41, 8'h42, 8'h43, 8'h07};
    repeat (4) @(posedge CLOCK);
    RESET_N <= 1'b1;
    @(posedge CLOCK);
    foreach (idxs[j]) rchk(idxs[j], low_power_card_detect_pkg::REG_RST);
    axi_rd(8'h10);
    chk8({6'h0, resp}, {6'h0, low_power_card_detect_pkg::RESP_SLVERR});
    axi_wr(8'h10, 8'hff);
    chk8({6'h0, resp}, {6'h0, low_power_card_detect_pkg::RESP_SLVERR});
    axi_wr(low_power_card_detect_pkg::OPT_IDX, 8'hff);
    rchk(low_power_card_detect_pkg::OPT_IDX, 8'h0c);
    chk1(DETECT_HIGH_DRIVE, 1'b1);
    axi_wr(low_power_card_detect_pkg::OPT_IDX, 8'h00);
    chk1(DETECT_HIGH_DRIVE, 1'b0);
    axi_wr(low_power_card_detect_pkg::RESI_IDX, 8'hff);
    rchk(low_power_card_detect_pkg::RESI_IDX, 8'h00);
    // borders: upper I 42, lower I 5, upper Q 0x30, lower Q 0
    bord(8'h80, 8'hb0, 8'h85);
    rchk(low_power_card_detect_pkg::ILO_IDX, 8'h85);
    // low byte strobe off, nothing may be stored
    wstb = 4'he;
    axi_wr(low_power_card_detect_pkg::ILO_IDX, 8'h00);
    wstb = 4'hf;
    rchk(low_power_card_detect_pkg::ILO_IDX, 8'h85);
    run(6'h3f, 6'h3f, 6'd42, 6'h30, 1'b0, 1'b0);
    run(6'h00, 6'h00, 6'd43, 6'h30, 1'b0, 1'b0);
    run(6'h3f, 6'h3f, 6'd5, 6'h00, 1'b0, 1'b0);
    run(6'h3f, 6'h00, 6'd4, 6'h00, 1'b0, 1'b0);
    run(6'h00, 6'h00, 6'd10, 6'h31, 1'b0, 1'b0);
    for (k = 0; k < 16; k++) begin
      bord(8'($random(seed)), 8'($random(seed)), 8'($random(seed)));
      run(6'($random(seed)), 6'($random(seed)), 6'($random(seed)),
          6'($random(seed)), 1'b0, 1'b0);
    end
    // suppress set mid-run, then lifted by the next start
    bord(8'h80, 8'hb0, 8'h85);
    run(6'h00, 6'h00, 6'd43, 6'h30, 1'b0, 1'b1);
    run(6'h00, 6'h00, 6'd43, 6'h30, 1'b0, 1'b0);
    axi_wr(low_power_card_detect_pkg::OPT_IDX, 8'h04);
    run(6'd60, 6'h30, 6'd40, 6'h30, 1'b1, 1'b0);
    rchk(low_power_card_detect_pkg::OPT_IDX, 8'h05);
    axi_wr(low_power_card_detect_pkg::OPT_IDX, 8'h00);
    rchk(low_power_card_detect_pkg::OPT_IDX, 8'h00);
    axi_wr(low_power_card_detect_pkg::OPT_IDX, 8'h04);
    run(6'd40, 6'h20, 6'd40, 6'h30, 1'b1, 1'b0);
    rchk(low_power_card_detect_pkg::OPT_IDX, 8'h06);
    run(6'd40, 6'h30, 6'd40, 6'h30, 1'b1, 1'b0);
    rchk(low_power_card_detect_pkg::OPT_IDX, 8'h04);
    // last sample inside the window kept, the one after it dropped
    RUN_START <= 1'b1;
    @(posedge CLOCK);
    RUN_START <= 1'b0;
    repeat (low_power_card_detect_pkg::SAMPLE_MAX_CYC - 1) @(posedge CLOCK);
    SAMPLE_VALID <= 1'b1;
    SAMPLE <= {6'h14, 6'h10};
    @(posedge CLOCK);
    SAMPLE <= 12'hfff;
    @(posedge CLOCK);
    SAMPLE_VALID <= 1'b0;
    RUN_END <= 1'b1;
    @(posedge CLOCK);
    RUN_END <= 1'b0;
    @(posedge CLOCK);
    chk1(DETECT_IRQ, 1'b0);
    rchk(low_power_card_detect_pkg::RESI_IDX, 8'h14);
    rchk(low_power_card_detect_pkg::RESQ_IDX, 8'h10);
    rchk(low_power_card_detect_pkg::OPT_IDX, 8'h04);
    test_done();
  end

  // hang guard, run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge CLOCK);
    mismatches++;
    test_done();
  end
endmodule
